/* File: verilog/smpc_pkg.sv */
/*
 * Shared constants and types for the SPI master pin-control block.
 * Assumes a system clock of 10 MHz and a separate, faster link clock that paces the serial engine.
 */
package smpc_pkg;

	// ----------------------------------------------------------------
	// Data path
	// ----------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 16;

	typedef struct packed
	{
		logic last;
		logic [DATA_W-1:0] data;
	} smpc_word_s;

	localparam int WORD_W = $bits(smpc_word_s);

	// ----------------------------------------------------------------
	// Serial clock rates and link clock
	// ----------------------------------------------------------------
	localparam longint SCLK_SLOW_HZ = 30_000_000;
	localparam longint SCLK_FAST_HZ = 60_000_000;
	localparam longint LINK_CLK_HZ_DEF = 120_000_000;
	localparam int DIV_W = 8;
	localparam int BIT_W = 4;
	localparam logic [BIT_W-1:0] BITS_PER_WORD = 4'h8;

	// ----------------------------------------------------------------
	// Strap handling
	// ----------------------------------------------------------------
	localparam logic STRAP_SLOW = 1'b0;
	localparam logic STRAP_FAST = 1'b1;
	localparam logic STRAP_DRIVE_LVL = 1'b0;
	localparam int CAP_W = 2;
	localparam logic [CAP_W-1:0] STRAP_CAPTURE_CYC = 2'h3;

	// ----------------------------------------------------------------
	// Reset values and states
	// ----------------------------------------------------------------
	localparam logic CE_N_IDLE = 1'b1;

	typedef enum logic [1:0]
	{
		SEQ_IDLE = 2'b00,
		SEQ_LAUNCH = 2'b01,
		SEQ_WAIT = 2'b10
	} smpc_seq_e;

	typedef enum logic
	{
		SHF_IDLE = 1'b0,
		SHF_RUN = 1'b1
	} smpc_shf_e;

endpackage : smpc_pkg

/* File: verilog/smpc_fifo.sv */
/*
 * Word FIFO with a registered read port and registered write ready.
 * Assumes both sides run on one clock; total capacity is DEPTH words (DEPTH-1 in memory plus the output register).
 */
`timescale 1ns/10ps

module smpc_fifo #(
	parameter int WIDTH = smpc_pkg::WORD_W,
	parameter int DEPTH = smpc_pkg::FIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic wr_valid_i,
	output logic wr_ready_o,
	input wire logic [WIDTH-1:0] wr_data_i,
	output logic rd_valid_o,
	input wire logic rd_ready_i,
	output logic [WIDTH-1:0] rd_data_o
);

	localparam int MEM_D = DEPTH - 1;
	localparam int PTR_W = $clog2(MEM_D);
	localparam int CNT_W = $clog2(DEPTH);
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(MEM_D - 1);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(MEM_D);

	logic [WIDTH-1:0] mem_ff [MEM_D];
	logic [PTR_W-1:0] wr_ptr_ff;
	logic [PTR_W-1:0] rd_ptr_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic ready_ff;
	logic out_vld_ff;
	logic [WIDTH-1:0] out_data_ff;

	wire logic push = wr_valid_i && ready_ff;
	wire logic load = (cnt_ff != '0) && (!out_vld_ff || rd_ready_i);
	wire logic [CNT_W-1:0] nxt_cnt = cnt_ff + CNT_W'(push) - CNT_W'(load);
	wire logic [PTR_W-1:0] nxt_wr_ptr = (wr_ptr_ff == PTR_LAST) ? '0 : wr_ptr_ff + 1'b1;
	wire logic [PTR_W-1:0] nxt_rd_ptr = (rd_ptr_ff == PTR_LAST) ? '0 : rd_ptr_ff + 1'b1;

	// ----------------------------------------------------------------
	// Storage, no reset needed on the array itself
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (push)
			mem_ff[wr_ptr_ff] <= wr_data_i;
	end

	// ----------------------------------------------------------------
	// Pointers, fill level and output register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff <= '0;
			ready_ff <= 1'b0;
			out_vld_ff <= 1'b0;
			out_data_ff <= '0;
		end
		else
		begin
			cnt_ff <= nxt_cnt;
			ready_ff <= (nxt_cnt != CNT_FULL);
			if (push)
				wr_ptr_ff <= nxt_wr_ptr;
			if (load)
			begin
				rd_ptr_ff <= nxt_rd_ptr;
				out_data_ff <= mem_ff[rd_ptr_ff];
				out_vld_ff <= 1'b1;
			end
			else if (rd_ready_i)
				out_vld_ff <= 1'b0;
		end
	end

	assign wr_ready_o = ready_ff;
	assign rd_valid_o = out_vld_ff;
	assign rd_data_o = out_data_ff;

endmodule : smpc_fifo

/* File: verilog/smpc_spi_pins.sv */
/*
 * SPI master pin control: chip enable, serial clock and data, and the rate strap pin.
 * Assumes suspend, powerdown and enable come from logic on clk_i, and link_clk_i runs freely from a local PLL.
 */
// Contract
// - Chip enable is driven low to select the peripheral and high to release it.
// - While the port is enabled, chip enable is held high in every powerdown state.
// - The strap picks the serial clock rate, 0 for 30 MHz by default and 1 for 60 MHz.
// - The strap is latched at reset and a latched 1 leaves the strap pin undriven in suspend.
// - A latched 0 makes the device drive the strap pin low for the whole of suspend; the drive lags suspend_i by one clk_i cycle.
`timescale 1ns/10ps

module smpc_spi_pins #(
	parameter longint LINK_CLK_HZ = smpc_pkg::LINK_CLK_HZ_DEF,
	parameter int DEPTH = smpc_pkg::FIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic link_clk_i,
	input wire logic spi_enable_i,
	input wire logic powerdown_i,
	input wire logic suspend_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	input wire smpc_pkg::smpc_word_s tx_word_i,
	output logic rx_valid_o,
	output logic [smpc_pkg::DATA_W-1:0] rx_data_o,
	output logic rate_fast_o,
	output logic spi_ce_n_o,
	output logic spi_clk_o,
	output logic spi_do_o,
	input wire logic serial_data_in_i,
	input wire logic link_rate_strap_i,
	output logic link_rate_strap_o,
	output logic link_rate_strap_oe_o
);

	// ----------------------------------------------------------------
	// Half periods of the serial clock in link clock cycles
	// ----------------------------------------------------------------
	// The serial clock is a most-rate figure, so the half period rounds up and never falls below one cycle.
	localparam longint HP_FAST_L = (LINK_CLK_HZ + 2 * smpc_pkg::SCLK_FAST_HZ - 1) / (2 * smpc_pkg::SCLK_FAST_HZ);
	localparam longint HP_SLOW_L = (LINK_CLK_HZ + 2 * smpc_pkg::SCLK_SLOW_HZ - 1) / (2 * smpc_pkg::SCLK_SLOW_HZ);
	localparam logic [smpc_pkg::DIV_W-1:0] HP_FAST = smpc_pkg::DIV_W'((HP_FAST_L < 1) ? 1 : HP_FAST_L);
	localparam logic [smpc_pkg::DIV_W-1:0] HP_SLOW = smpc_pkg::DIV_W'((HP_SLOW_L < 1) ? 1 : HP_SLOW_L);

	// ----------------------------------------------------------------
	// System domain declarations
	// ----------------------------------------------------------------
	logic strap_meta_ff;
	logic strap_sync_ff;
	logic [smpc_pkg::CAP_W-1:0] cap_cnt_ff;
	logic cap_done_ff;
	logic strap_lat_ff;
	logic strap_oe_ff;
	logic strap_out_ff;
	smpc_pkg::smpc_seq_e seq_ff;
	smpc_pkg::smpc_word_s tx_word_ff;
	logic ce_n_ff;
	logic req_tgl_ff;
	logic ack_meta_ff;
	logic ack_sync_ff;
	logic ack_seen_ff;
	logic rx_valid_ff;
	logic [smpc_pkg::DATA_W-1:0] rx_data_ff;
	logic fifo_rd_valid;
	smpc_pkg::smpc_word_s fifo_rd_word;

	// ----------------------------------------------------------------
	// Link domain declarations
	// ----------------------------------------------------------------
	logic lrst_meta_ff;
	logic lrst_n_ff;
	logic req_meta_ff;
	logic req_sync_ff;
	logic req_seen_ff;
	logic rate_meta_ff;
	logic rate_sync_ff;
	logic ce_meta_ff;
	logic ce_sync_ff;
	logic miso_meta_ff;
	logic miso_sync_ff;
	smpc_pkg::smpc_shf_e shf_ff;
	logic [smpc_pkg::DIV_W-1:0] div_ff;
	logic [smpc_pkg::BIT_W-1:0] bit_ff;
	logic sclk_ff;
	logic mosi_ff;
	logic [smpc_pkg::DATA_W-1:0] txsh_ff;
	logic [smpc_pkg::DATA_W-1:0] rxsh_ff;
	logic [smpc_pkg::DATA_W-1:0] rx_hold_ff;
	logic ack_tgl_ff;

	// ----------------------------------------------------------------
	// Transmit buffer
	// ----------------------------------------------------------------
	wire logic port_ok = spi_enable_i && !powerdown_i && !suspend_i && cap_done_ff;
	wire logic fifo_rd_ready = (seq_ff == smpc_pkg::SEQ_IDLE) && port_ok;
	wire logic pop = fifo_rd_valid && fifo_rd_ready;
	wire logic ack_evt = ack_sync_ff ^ ack_seen_ff;
	wire logic word_end = (seq_ff == smpc_pkg::SEQ_WAIT) && ack_evt;

	smpc_fifo #(
		.WIDTH(smpc_pkg::WORD_W),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.wr_valid_i(tx_valid_i),
		.wr_ready_o(tx_ready_o),
		.wr_data_i(tx_word_i),
		.rd_valid_o(fifo_rd_valid),
		.rd_ready_i(fifo_rd_ready),
		.rd_data_o(fifo_rd_word)
	);

	// ----------------------------------------------------------------
	// Strap capture after reset release
	// ----------------------------------------------------------------
	// The pin passes two flops, so the latch waits until the synchroniser holds a post-reset sample.
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			strap_meta_ff <= smpc_pkg::STRAP_SLOW;
			strap_sync_ff <= smpc_pkg::STRAP_SLOW;
			cap_cnt_ff <= '0;
			cap_done_ff <= 1'b0;
			strap_lat_ff <= smpc_pkg::STRAP_SLOW;
		end
		else
		begin
			strap_meta_ff <= link_rate_strap_i;
			strap_sync_ff <= strap_meta_ff;
			if (!cap_done_ff)
				cap_cnt_ff <= cap_cnt_ff + 1'b1;
			if (!cap_done_ff && cap_cnt_ff == smpc_pkg::STRAP_CAPTURE_CYC)
			begin
				cap_done_ff <= 1'b1;
				strap_lat_ff <= strap_sync_ff;
			end
		end
	end

	// ----------------------------------------------------------------
	// Strap pin drive in suspend
	// ----------------------------------------------------------------
	wire logic strap_drive = cap_done_ff && suspend_i && (strap_lat_ff == smpc_pkg::STRAP_SLOW);

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			strap_oe_ff <= 1'b0;
			strap_out_ff <= smpc_pkg::STRAP_DRIVE_LVL;
		end
		else
		begin
			strap_oe_ff <= strap_drive;
			strap_out_ff <= smpc_pkg::STRAP_DRIVE_LVL;
		end
	end

	// ----------------------------------------------------------------
	// Word sequencer and chip enable
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			seq_ff <= smpc_pkg::SEQ_IDLE;
			tx_word_ff <= '0;
			req_tgl_ff <= 1'b0;
		end
		else
		begin
			case (seq_ff)
				smpc_pkg::SEQ_IDLE:
				begin
					if (pop)
					begin
						tx_word_ff <= fifo_rd_word;
						seq_ff <= smpc_pkg::SEQ_LAUNCH;
					end
				end
				smpc_pkg::SEQ_LAUNCH:
				begin
					// Chip enable went low a cycle earlier, giving setup before the first clock edge.
					req_tgl_ff <= ~req_tgl_ff;
					seq_ff <= smpc_pkg::SEQ_WAIT;
				end
				smpc_pkg::SEQ_WAIT:
				begin
					if (ack_evt)
						seq_ff <= smpc_pkg::SEQ_IDLE;
				end
				default:
					seq_ff <= smpc_pkg::SEQ_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			ce_n_ff <= smpc_pkg::CE_N_IDLE;
		else if (!spi_enable_i || powerdown_i || suspend_i)
			ce_n_ff <= smpc_pkg::CE_N_IDLE;
		else if (pop)
			ce_n_ff <= 1'b0;
		else if (word_end && tx_word_ff.last)
			ce_n_ff <= smpc_pkg::CE_N_IDLE;
	end

	// ----------------------------------------------------------------
	// Completion crossing back from the link
	// ----------------------------------------------------------------
	// The held receive word is stable from the acknowledge toggle until the next request, so it is read directly.
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			ack_meta_ff <= 1'b0;
			ack_sync_ff <= 1'b0;
			ack_seen_ff <= 1'b0;
			rx_valid_ff <= 1'b0;
			rx_data_ff <= '0;
		end
		else
		begin
			ack_meta_ff <= ack_tgl_ff;
			ack_sync_ff <= ack_meta_ff;
			ack_seen_ff <= ack_sync_ff;
			rx_valid_ff <= word_end;
			if (word_end)
				rx_data_ff <= rx_hold_ff;
		end
	end

	// ----------------------------------------------------------------
	// Link domain reset and synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge link_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			lrst_meta_ff <= 1'b0;
			lrst_n_ff <= 1'b0;
		end
		else
		begin
			lrst_meta_ff <= 1'b1;
			lrst_n_ff <= lrst_meta_ff;
		end
	end

	// Input data also passes two flops, which limits usable peripheral output delay at the fast rate.
	always_ff @(posedge link_clk_i or negedge lrst_n_ff)
	begin
		if (!lrst_n_ff)
		begin
			req_meta_ff <= 1'b0;
			req_sync_ff <= 1'b0;
			rate_meta_ff <= smpc_pkg::STRAP_SLOW;
			rate_sync_ff <= smpc_pkg::STRAP_SLOW;
			ce_meta_ff <= smpc_pkg::CE_N_IDLE;
			ce_sync_ff <= smpc_pkg::CE_N_IDLE;
			miso_meta_ff <= 1'b0;
			miso_sync_ff <= 1'b0;
		end
		else
		begin
			req_meta_ff <= req_tgl_ff;
			req_sync_ff <= req_meta_ff;
			rate_meta_ff <= strap_lat_ff;
			rate_sync_ff <= rate_meta_ff;
			ce_meta_ff <= ce_n_ff;
			ce_sync_ff <= ce_meta_ff;
			miso_meta_ff <= serial_data_in_i;
			miso_sync_ff <= miso_meta_ff;
		end
	end

	// ----------------------------------------------------------------
	// Serial engine, mode 0: data changes on falling edges, sampled on rising
	// ----------------------------------------------------------------
	wire logic start = (req_sync_ff ^ req_seen_ff) && (shf_ff == smpc_pkg::SHF_IDLE);
	wire logic [smpc_pkg::DIV_W-1:0] half_per = (rate_sync_ff == smpc_pkg::STRAP_FAST) ? HP_FAST : HP_SLOW;
	wire logic tick = (shf_ff == smpc_pkg::SHF_RUN) && (div_ff == half_per - 1'b1);
	wire logic rise = tick && !sclk_ff;
	wire logic fall = tick && sclk_ff;
	wire logic done = fall && (bit_ff == '0);
	wire logic sample_ok = rise && (ce_sync_ff == 1'b0);

	always_ff @(posedge link_clk_i or negedge lrst_n_ff)
	begin
		if (!lrst_n_ff)
		begin
			shf_ff <= smpc_pkg::SHF_IDLE;
			req_seen_ff <= 1'b0;
			div_ff <= '0;
			bit_ff <= '0;
		end
		else
		begin
			case (shf_ff)
				smpc_pkg::SHF_IDLE:
				begin
					if (start)
					begin
						req_seen_ff <= req_sync_ff;
						bit_ff <= smpc_pkg::BITS_PER_WORD;
						div_ff <= '0;
						shf_ff <= smpc_pkg::SHF_RUN;
					end
				end
				smpc_pkg::SHF_RUN:
				begin
					div_ff <= tick ? '0 : div_ff + 1'b1;
					if (rise)
						bit_ff <= bit_ff - 1'b1;
					if (done)
						shf_ff <= smpc_pkg::SHF_IDLE;
				end
				default:
					shf_ff <= smpc_pkg::SHF_IDLE;
			endcase
		end
	end

	// The transmit word is held by the request handshake, so the link side reads it without a further flop.
	always_ff @(posedge link_clk_i or negedge lrst_n_ff)
	begin
		if (!lrst_n_ff)
		begin
			sclk_ff <= 1'b0;
			mosi_ff <= 1'b0;
			txsh_ff <= '0;
		end
		else if (start)
		begin
			mosi_ff <= tx_word_ff.data[smpc_pkg::DATA_W-1];
			txsh_ff <= tx_word_ff.data << 1;
		end
		else if (tick)
		begin
			sclk_ff <= ~sclk_ff;
			if (fall && !done)
			begin
				mosi_ff <= txsh_ff[smpc_pkg::DATA_W-1];
				txsh_ff <= txsh_ff << 1;
			end
		end
	end

	always_ff @(posedge link_clk_i or negedge lrst_n_ff)
	begin
		if (!lrst_n_ff)
		begin
			rxsh_ff <= '0;
			rx_hold_ff <= '0;
			ack_tgl_ff <= 1'b0;
		end
		else
		begin
			if (sample_ok)
				rxsh_ff <= {rxsh_ff[smpc_pkg::DATA_W-2:0], miso_sync_ff};
			if (done)
			begin
				rx_hold_ff <= rxsh_ff;
				ack_tgl_ff <= ~ack_tgl_ff;
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Reset width is the outside party's duty; the strap latch only needs the release edge.
	assign spi_ce_n_o = ce_n_ff;
	assign spi_clk_o = sclk_ff;
	assign spi_do_o = mosi_ff;
	assign rx_valid_o = rx_valid_ff;
	assign rx_data_o = rx_data_ff;
	assign rate_fast_o = strap_lat_ff;
	assign link_rate_strap_o = strap_out_ff;
	assign link_rate_strap_oe_o = strap_oe_ff;

endmodule : smpc_spi_pins

/* File: test/smpc_spi_pins_monitor.sv */
/*
 * Concurrent checks on the SPI pin-control top: chip enable, rate latch and strap pin drive.
 * Assumes it is bound to smpc_spi_pins and sees only that module's ports.
 */
`timescale 1ns/10ps

module smpc_spi_pins_monitor #(
	parameter longint LINK_CLK_HZ = smpc_pkg::LINK_CLK_HZ_DEF,
	parameter int DEPTH = smpc_pkg::FIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic spi_enable_i,
	input wire logic powerdown_i,
	input wire logic suspend_i,
	input wire logic rate_fast_o,
	input wire logic spi_ce_n_o,
	input wire logic spi_clk_o,
	input wire logic link_rate_strap_o,
	input wire logic link_rate_strap_oe_o
);
	// ----------------------------------------------------------------
	// Helper logic and sequences
	// ----------------------------------------------------------------
	// The latch settles four edges after release, so stability is only demanded from edge six on.
	logic [2:0] since_rst_ff;
	always_ff @(posedge clk_i or negedge reset_n_i)
		if (!reset_n_i)
			since_rst_ff <= 3'h0;
		else if (since_rst_ff != 3'h7)
			since_rst_ff <= since_rst_ff + 3'h1;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	sequence ce_drop_s;
		$fell(spi_ce_n_o);
	endsequence

	sequence slow_susp_s;
		(suspend_i && !rate_fast_o) [*3];
	endsequence

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	ce_pd_a: assert property (powerdown_i |=> spi_ce_n_o)
		else $error("chip enable low during powerdown");
	ce_susp_a: assert property (suspend_i |=> spi_ce_n_o)
		else $error("chip enable low during suspend");
	ce_dis_a: assert property (!spi_enable_i |=> spi_ce_n_o)
		else $error("chip enable low while port disabled");
	ce_early_a: assert property (ce_drop_s |-> !spi_clk_o)
		else $error("serial clock high when chip enable fell");
	strap_low_a: assert property (link_rate_strap_oe_o |-> !link_rate_strap_o)
		else $error("strap pin driven high");
	strap_tri_a: assert property (rate_fast_o |-> !link_rate_strap_oe_o)
		else $error("strap pin driven with fast rate latched");
	strap_drive_a: assert property (slow_susp_s |-> link_rate_strap_oe_o)
		else $error("strap pin not driven in suspend");
	strap_off_a: assert property ((!suspend_i) [*3] |-> !link_rate_strap_oe_o)
		else $error("strap pin driven outside suspend");
	rate_hold_a: assert property (since_rst_ff >= 3'h6 |-> $stable(rate_fast_o))
		else $error("latched rate changed after reset");
endmodule : smpc_spi_pins_monitor

bind smpc_spi_pins smpc_spi_pins_monitor #(.LINK_CLK_HZ(LINK_CLK_HZ), .DEPTH(DEPTH)) mon_u (
	.clk_i(clk_i),
	.reset_n_i(reset_n_i),
	.spi_enable_i(spi_enable_i),
	.powerdown_i(powerdown_i),
	.suspend_i(suspend_i),
	.rate_fast_o(rate_fast_o),
	.spi_ce_n_o(spi_ce_n_o),
	.spi_clk_o(spi_clk_o),
	.link_rate_strap_o(link_rate_strap_o),
	.link_rate_strap_oe_o(link_rate_strap_oe_o)
);

/* File: test/smpc_periph.sv */
/*
 * Behavioural SPI peripheral, mode 0: captures bytes MSB first and answers with a steady level.
 * Assumes the bench picks the answer level; while deselected the data line toggles on every rising clk_i edge.
 */
`timescale 1ns/10ps

module smpc_periph (
	input wire logic clk_i,
	input wire logic spi_ce_n_i,
	input wire logic spi_clk_i,
	input wire logic spi_do_i,
	input wire logic resp_lvl_i,
	output logic serial_data_o,
	output logic [7:0] got_byte_o,
	output logic [7:0] got_cnt_o
);
	logic [7:0] shift;
	logic [2:0] nbits;
	logic idle_lvl;

	initial
	begin
		shift = 8'h00;
		nbits = 3'h0;
		idle_lvl = 1'b0;
		got_byte_o = 8'h00;
		got_cnt_o = 8'h00;
	end

	// A released line must not look like valid data, so it keeps changing.
	always @(posedge clk_i)
		if (spi_ce_n_i)
			idle_lvl <= ~idle_lvl;
	assign serial_data_o = spi_ce_n_i ? idle_lvl : resp_lvl_i;

	always @(posedge spi_ce_n_i)
		nbits = 3'h0;

	always @(posedge spi_clk_i)
		if (!spi_ce_n_i)
		begin
			shift = {shift[6:0], spi_do_i};
			nbits = nbits + 3'h1;
			if (nbits == 3'h0)
			begin
				got_byte_o = shift;
				got_cnt_o = got_cnt_o + 8'h01;
			end
		end
endmodule : smpc_periph

/* File: test/tb.sv */
/*
 * Self-checking bench for the SPI pin-control block with a peripheral model on the link.
 * Assumes a 10 MHz system clock, a free 30 ns link clock and a bench-driven level on the strap pin.
 */
`timescale 1ns/10ps

module tb;
	logic clk_i = 0, link_clk = 0, reset_n_i = 0, en = 0, pd = 0, susp = 0;
	logic tx_valid = 0, strap = 0, resp = 0;
	smpc_pkg::smpc_word_s tx_word = '0;
	logic tx_ready, rx_valid, rate_fast, ce_n, sclk, sdo, sdi, strap_o, strap_oe, strap_w;
	logic [7:0] rx_data, got_byte, got_cnt, rx_last = 8'h00, base;
	int errors = 0, num_checks = 0, rx_cnt = 0, n, mark, hi_len = 0, hi_run = 0;
	// The divider is set as for a faster link clock, so the two rates give different half periods.
	localparam longint LINK_HZ = 240_000_000;
	logic [1:0] rows [4] = '{2'b01, 2'b10, 2'b00, 2'b11};

	initial forever #50 clk_i = ~clk_i;
	initial
	begin
		#7;
		forever #15 link_clk = ~link_clk;
	end
	assign strap_w = strap_oe ? strap_o : strap;

	smpc_spi_pins #(.LINK_CLK_HZ(LINK_HZ), .DEPTH(16)) dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.link_clk_i(link_clk), .spi_enable_i(en), .powerdown_i(pd), .suspend_i(susp), .tx_valid_i(tx_valid),
		.tx_ready_o(tx_ready), .tx_word_i(tx_word), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
		.rate_fast_o(rate_fast), .spi_ce_n_o(ce_n), .spi_clk_o(sclk), .spi_do_o(sdo), .serial_data_in_i(sdi),
		.link_rate_strap_i(strap_w), .link_rate_strap_o(strap_o), .link_rate_strap_oe_o(strap_oe));
	smpc_periph per_u (.clk_i(clk_i), .spi_ce_n_i(ce_n), .spi_clk_i(sclk), .spi_do_i(sdo), .resp_lvl_i(resp),
		.serial_data_o(sdi), .got_byte_o(got_byte), .got_cnt_o(got_cnt));

	always @(negedge clk_i)
		if (rx_valid === 1'b1)
		begin
			rx_cnt++;
			rx_last = rx_data;
		end

	// Length of the last high phase of the serial clock, in link clock cycles.
	always @(posedge link_clk)
		if (sclk === 1'b1)
			hi_run++;
		else if (hi_run != 0)
		begin
			hi_len = hi_run;
			hi_run = 0;
		end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic summarize;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic timeout;
		errors++;
		$display("mismatch at %0t: wait ran out, got %h expected %h", $time, 8'h00, 8'h01);
		summarize();
	endtask : timeout

	// Hold for 50 edges so the pulse meets the 5 us minimum.
	task automatic do_reset(input logic s);
		@(negedge clk_i);
		reset_n_i = 0;
		strap = s;
		repeat (50) @(negedge clk_i);
		reset_n_i = 1;
		repeat (6) @(negedge clk_i);
	endtask : do_reset

	// Valid stays up on return so back-to-back pushes never lower and raise it in one step.
	task automatic push(input logic lst, input logic [7:0] d);
		n = 0;
		while (tx_ready !== 1'b1)
		begin
			@(negedge clk_i);
			if (++n > 2000)
				timeout();
		end
		tx_word = {lst, d};
		tx_valid = 1;
		@(negedge clk_i);
	endtask : push

	task automatic wait_rx(input int target);
		tx_valid = 0;
		n = 0;
		while (rx_cnt < target || ce_n !== 1'b1)
		begin
			@(negedge clk_i);
			if (++n > 3000)
				timeout();
		end
	endtask : wait_rx

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		for (int i = 0; i < 4; i++)
		begin
			do_reset(rows[i][1]);
			chk(8'(rate_fast), 8'(rows[i][1]));
			chk(8'(ce_n), 8'h01);
			en = 1;
			resp = rows[i][0];
			base = got_cnt;
			push(1'b0, 8'hA5);
			push(1'b1, 8'h3C ^ 8'(i));
			wait_rx(rx_cnt + 2);
			chk(got_cnt - base, 8'h02);
			chk(got_byte, 8'h3C ^ 8'(i));
			chk(rx_last, {8{rows[i][0]}});
			chk(8'(hi_len), 8'(LINK_HZ / (2 * (rows[i][1] ? smpc_pkg::SCLK_FAST_HZ : smpc_pkg::SCLK_SLOW_HZ))));
			susp = 1;
			repeat (4) @(negedge clk_i);
			chk(8'(strap_oe), 8'(!rows[i][1]));
			chk(8'(strap_w), 8'(rows[i][1]));
			chk(8'(ce_n), 8'h01);
			susp = 0;
			repeat (4) @(negedge clk_i);
			chk(8'(strap_oe), 8'h00);
		end
		en = 0;
		base = got_cnt;
		for (int i = 0; i < 16; i++)
			push(i == 15, 8'(i));
		tx_valid = 0;
		repeat (3) @(negedge clk_i);
		chk(8'(tx_ready), 8'h00);
		chk(got_cnt - base, 8'h00);
		en = 1;
		wait_rx(rx_cnt + 16);
		chk(got_cnt - base, 8'h10);
		chk(got_byte, 8'h0F);
		chk(8'(tx_ready), 8'h01);
		mark = rx_cnt;
		push(1'b0, 8'h55);
		tx_valid = 0;
		n = 0;
		while (ce_n !== 1'b0)
		begin
			@(negedge clk_i);
			if (++n > 20)
				timeout();
		end
		pd = 1;
		repeat (2) @(negedge clk_i);
		chk(8'(ce_n), 8'h01);
		wait_rx(mark + 1);
		chk(rx_last, 8'hFF);
		pd = 0;
		push(1'b1, 8'h66);
		wait_rx(mark + 2);
		chk(8'(ce_n), 8'h01);
		chk(got_cnt - base, 8'h11);
		chk(got_byte, 8'h66);
		summarize();
	end
endmodule : tb
